// File: core/bank_select_decode.sv
// Decodes the bank field of the external address into active-low selects.
// Assumes the caller registers the result alongside the address pins.
`timescale 1ns/10ps
module bank_select_decode (
   input  wire logic [1:0]                  bank_field,
   input  wire logic                        active,
   input  wire logic                        boot_flash,
   output logic [ext_mem_pkg::BANKS-1:0]    select_n
);
   import ext_mem_pkg::*;

   // ==========================================================
   // One select per bank; flash boot forces bank one
   for (genvar i = 0; i < BANKS; i++) begin : g_bank
      wire hit_addr  = (bank_field == 2'(i));
      wire hit_boot  = (i == FLASH_BANK);
      assign select_n[i] = !(active && (boot_flash ? hit_boot : hit_addr));
   end
endmodule : bank_select_decode

// File: core/ext_mem_pkg.sv
// Constants, carriers and state codes for the external memory pin logic.
// Assumes a single 250 MHz core_clk domain.
package ext_mem_pkg;
   // ==========================================================
   // Widths and bank layout
   localparam int ADDR_W     = 24;
   localparam int DATA_W     = 32;
   localparam int BANKS      = 4;
   localparam int BANK_MSB   = 23;
   localparam int BANK_LSB   = 22;
   localparam int SDRAM_BANK = 0;
   localparam int FLASH_BANK = 1;
   localparam int TEN_BIT    = 10;

   // ==========================================================
   // Reset values and the flash boot select pattern
   localparam logic [3:0] SEL_IDLE   = 4'hf;
   localparam logic       CKE_RESET  = 1'h1;
   localparam logic       TEN_RESET  = 1'h0;
   localparam logic [3:0] SEL_FLASH  = 4'hd;

   // ==========================================================
   // Timing, least times rounded up
   localparam int CLK_PERIOD_PS = 4000;
   localparam int STROBE_MIN_NS = 20;
   localparam int CKE_WAKE_NS   = 8;
   localparam int STROBE_CYCLES = (STROBE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WAKE_CYCLES   = (CKE_WAKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic              write;
      logic              cond_true;
      logic [DATA_W-1:0] wdata;
   } mem_req_type;

   typedef struct packed {
      logic ras_n;
      logic cas_n;
      logic we_n;
   } sdram_cmd_type;

   localparam sdram_cmd_type CMD_NOP       = 3'h7;
   localparam sdram_cmd_type CMD_ACTIVATE  = 3'h3;
   localparam sdram_cmd_type CMD_PRECHARGE = 3'h2;
   localparam sdram_cmd_type CMD_REFRESH   = 3'h1;

   // ==========================================================
   // State codes, Gray along the access path; refresh returning to idle flips two bits
   typedef enum logic [1:0] {
      ST_IDLE   = 2'h0,
      ST_SETUP  = 2'h1,
      ST_STROBE = 2'h3,
      ST_HOLD   = 2'h2
   } access_state_type;

   typedef enum logic [1:0] {
      RF_IDLE      = 2'h0,
      RF_PRECHARGE = 2'h1,
      RF_REFRESH   = 2'h3
   } refresh_state_type;
endpackage : ext_mem_pkg

// File: core/ext_memory_select_pins.sv
// External memory pin logic: bank selects, strobes, SDRAM address ten, CKE and refresh.
// Assumes requests and refresh pulses come from core_clk logic; pins are async.
//
// How it works
// R1: A bank select goes low while its own bank is being accessed.
// R2: Selects are decoded from the address and registered with the address pins.
// R3: All selects stay high whenever no external access is in progress.
// R4: A conditional access with false condition still drives its bank select.
// R5: SDRAM address bit ten goes on its dedicated pin only for SDRAM accesses.
// R6: Refresh runs on the dedicated pin while a non-SDRAM access proceeds.
// R7: CKE is raised ahead of any SDRAM command and may drop when idle.
// R8: Flash boot mode routes every access to bank select one.
// R9: A low acknowledge holds the strobe phase of a true-condition access open until it rises.
// R10: Read strobe is low for reads, write strobe low for writes.
// R11: Reset holds selects and CKE high and the address-ten pin low.
`timescale 1ns/10ps
module ext_memory_select_pins (
   input  wire logic                           core_clk,
   input  wire logic                           rst,
   input  wire logic                           req_valid,
   output logic                                req_ready,
   input  wire ext_mem_pkg::mem_req_type       req,
   output logic                                resp_valid,
   output logic [ext_mem_pkg::DATA_W-1:0]      resp_rdata,
   input  wire logic                           refresh_req,
   output logic                                refresh_busy,
   input  wire logic                           sdram_sleep,
   input  wire logic                           boot_flash_pin,
   input  wire logic                           ack_pin,
   input  wire logic [ext_mem_pkg::DATA_W-1:0] data_in,
   output logic [ext_mem_pkg::DATA_W-1:0]      data_out,
   output logic                                data_oe,
   output logic [ext_mem_pkg::ADDR_W-1:0]      ext_addr,
   output logic                                rd_n,
   output logic                                wr_n,
   output logic [ext_mem_pkg::BANKS-1:0]       mem_bank_select_n,
   output logic                                sdram_clk_en_out,
   output logic                                sdram_addr_bit_ten,
   output logic                                sdram_clock_out,
   output ext_mem_pkg::sdram_cmd_type          sdram_cmd
);
   import ext_mem_pkg::*;

   // ==========================================================
   // Pin synchronisers
   logic              ack_meta, ack_sync, boot_meta, boot_sync;
   logic [DATA_W-1:0] data_meta, data_sync;

   // Two flops on every pin input; first stage read only by second
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ack_meta  <= 1'h1;
         ack_sync  <= 1'h1;
         boot_meta <= 1'h0;
         boot_sync <= 1'h0;
         data_meta <= '0;
         data_sync <= '0;
      end else begin
         ack_meta  <= ack_pin;
         ack_sync  <= ack_meta;
         boot_meta <= boot_flash_pin;
         boot_sync <= boot_meta;
         data_meta <= data_in;
         data_sync <= data_meta;
      end
   end

   // ==========================================================
   // State
   access_state_type  state, next_state;
   refresh_state_type rf_state, next_rf_state;
   mem_req_type       cur;
   logic [7:0]        cnt;
   logic [7:0]        wake_cnt;
   logic              rf_pending;

   // ==========================================================
   // Decode of request and access kind
   wire req_sdram   = !boot_sync && (req.addr[BANK_MSB:BANK_LSB] == 2'(SDRAM_BANK));
   wire cur_sdram   = !boot_sync && (cur.addr[BANK_MSB:BANK_LSB] == 2'(SDRAM_BANK));
   wire sdram_busy  = (state != ST_IDLE) && cur_sdram;
   wire cke_ready   = sdram_clk_en_out && (wake_cnt == 8'h0);
   // SDRAM access must wait for refresh and a woken clock; others never do
   wire sdram_ok    = cke_ready && !rf_pending && (rf_state == RF_IDLE);
   assign req_ready = (state == ST_IDLE) && (!req_sdram || sdram_ok);
   wire take        = req_valid && req_ready;
   wire strobe_done = (cnt == 8'h0) && (ack_sync || !cur.cond_true); // R9
   wire rf_start    = rf_pending && cke_ready && !sdram_busy && !(take && req_sdram); // R6
   wire wants_cke   = !sdram_sleep || rf_pending || (rf_state != RF_IDLE) || sdram_busy
                      || (req_valid && req_sdram); // R7
   assign refresh_busy = rf_pending || (rf_state != RF_IDLE);

   // Access sequencer next state
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE:   if (take) next_state = ST_SETUP;
         ST_SETUP:  next_state = ST_STROBE;
         ST_STROBE: if (strobe_done) next_state = ST_HOLD; // R9
         ST_HOLD:   next_state = ST_IDLE;
      endcase
   end

   // Refresh sequencer next state
   always_comb begin
      next_rf_state = rf_state;
      unique case (rf_state)
         RF_IDLE:      if (rf_start) next_rf_state = RF_PRECHARGE;
         RF_PRECHARGE: next_rf_state = RF_REFRESH;
         RF_REFRESH:   next_rf_state = RF_IDLE;
         default:      next_rf_state = RF_IDLE;
      endcase
   end

   // ==========================================================
   // Next pin values, taken from the same request as the address
   mem_req_type next_cur;
   assign next_cur = take ? req : cur;
   wire next_active = (next_state != ST_IDLE);
   wire next_sdram  = next_active && !boot_sync
                      && (next_cur.addr[BANK_MSB:BANK_LSB] == 2'(SDRAM_BANK));
   wire next_xfer   = (next_state == ST_STROBE) && next_cur.cond_true; // R4
   wire next_rd_n   = !(next_xfer && !next_cur.write); // R10
   wire next_wr_n   = !(next_xfer && next_cur.write); // R10
   wire next_oe     = next_active && next_cur.write && next_cur.cond_true;
   // General bit-ten line parked low while the dedicated pin carries the bit
   wire addr_line_ten = next_sdram ? 1'h0 : next_cur.addr[TEN_BIT]; // R5
   wire [ADDR_W-1:0] next_addr = {next_cur.addr[ADDR_W-1:TEN_BIT+1], addr_line_ten,
                                  next_cur.addr[TEN_BIT-1:0]};
   // Precharge-all needs bit ten high; SDRAM access carries its own bit
   wire next_bit_ten = (next_rf_state == RF_PRECHARGE) ? 1'h1
                       : (next_sdram ? next_cur.addr[TEN_BIT] : TEN_RESET); // R5 R6
   logic [BANKS-1:0] next_sel;
   sdram_cmd_type    next_cmd;

   bank_select_decode u_decode (
      .bank_field (next_cur.addr[BANK_MSB:BANK_LSB]),
      .active     (next_active),
      .boot_flash (boot_sync),
      .select_n   (next_sel)
   );

   // SDRAM command: refresh pair, or activate then read/write
   always_comb begin
      next_cmd = CMD_NOP;
      if (next_rf_state == RF_PRECHARGE) next_cmd = CMD_PRECHARGE; // R6
      else if (next_rf_state == RF_REFRESH) next_cmd = CMD_REFRESH;
      else if (next_sdram && next_state == ST_SETUP) next_cmd = CMD_ACTIVATE;
      else if (next_sdram && next_state == ST_STROBE && state == ST_SETUP && next_cur.cond_true)
         next_cmd = '{ras_n: 1'h1, cas_n: 1'h0, we_n: !next_cur.write};
   end

   // ==========================================================
   // Sequencer registers
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state      <= ST_IDLE;
         rf_state   <= RF_IDLE;
         cur        <= '0;
         cnt        <= 8'h0;
         rf_pending <= 1'h0;
         resp_valid <= 1'h0;
         resp_rdata <= '0;
      end else begin
         state      <= next_state;
         rf_state   <= next_rf_state;
         cur        <= next_cur;
         // New request wins over the clear by a starting refresh
         rf_pending <= refresh_req || (rf_pending && !rf_start);
         resp_valid <= (state == ST_HOLD);
         if (state == ST_SETUP) cnt <= 8'(STROBE_CYCLES - 1);
         else if (state == ST_STROBE && cnt != 8'h0) cnt <= cnt - 8'h1;
         // A false conditional read never strobed, so its bus value is not kept
         if (state == ST_STROBE && strobe_done && !cur.write && cur.cond_true)
            resp_rdata <= data_sync;
      end
   end

   // Pin registers: selects move with the address
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mem_bank_select_n  <= SEL_IDLE; // R11
         ext_addr           <= '0;
         rd_n               <= 1'h1;
         wr_n               <= 1'h1;
         data_oe            <= 1'h0;
         data_out           <= '0;
         sdram_addr_bit_ten <= TEN_RESET; // R11
         sdram_cmd          <= CMD_NOP;
      end else begin
         mem_bank_select_n  <= next_sel; // R1 R2 R3 R8
         ext_addr           <= next_addr; // R2
         rd_n               <= next_rd_n;
         wr_n               <= next_wr_n;
         data_oe            <= next_oe;
         data_out           <= next_cur.wdata;
         sdram_addr_bit_ten <= next_bit_ten;
         sdram_cmd          <= next_cmd;
      end
   end

   // ==========================================================
   // Clock enable and SDRAM clock; wake count covers CKE setup
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sdram_clk_en_out <= CKE_RESET; // R11
         wake_cnt         <= 8'h0;
         sdram_clock_out  <= 1'h0;
      end else begin
         sdram_clock_out  <= !sdram_clock_out;
         sdram_clk_en_out <= wants_cke; // R7
         if (!sdram_clk_en_out && wants_cke) wake_cnt <= 8'(WAKE_CYCLES);
         else if (wake_cnt != 8'h0) wake_cnt <= wake_cnt - 8'h1;
      end
   end

   // ==========================================================
   // Checks
   a_idle_selects_high: assert property (@(posedge core_clk) disable iff (rst)
      state == ST_IDLE |-> mem_bank_select_n == SEL_IDLE) // R3
      else $error("bank select low with no access");

   a_one_select_low: assert property (@(posedge core_clk) disable iff (rst)
      state != ST_IDLE |-> $onehot(~mem_bank_select_n)) // R1
      else $error("not exactly one bank select low");

   a_select_follows_addr: assert property (@(posedge core_clk) disable iff (rst)
      (state != ST_IDLE && !boot_sync)
      |-> !mem_bank_select_n[ext_addr[BANK_MSB:BANK_LSB]]) // R2
      else $error("bank select does not match address");

   a_cond_false_select: assert property (@(posedge core_clk) disable iff (rst)
      (state == ST_STROBE && !cur.cond_true)
      |-> mem_bank_select_n != SEL_IDLE && rd_n && wr_n) // R4
      else $error("false condition lost its select or strobed");

   a_bit_ten_sdram: assert property (@(posedge core_clk) disable iff (rst)
      (!sdram_busy && rf_state == RF_IDLE) |-> !sdram_addr_bit_ten) // R5
      else $error("dedicated address-ten pin high outside SDRAM use");

   a_refresh_pair: assert property (@(posedge core_clk) disable iff (rst)
      rf_state == RF_PRECHARGE |-> sdram_addr_bit_ten && sdram_cmd == CMD_PRECHARGE
      ##1 rf_state == RF_REFRESH && sdram_cmd == CMD_REFRESH) // R6
      else $error("refresh sequence broken");

   a_cke_before_cmd: assert property (@(posedge core_clk) disable iff (rst)
      sdram_cmd != CMD_NOP |-> sdram_clk_en_out && $past(sdram_clk_en_out)) // R7
      else $error("SDRAM command without clock enable");

   a_boot_bank_one: assert property (@(posedge core_clk) disable iff (rst)
      (boot_sync && $past(boot_sync) && state != ST_IDLE)
      |-> mem_bank_select_n == SEL_FLASH) // R8
      else $error("flash boot not on bank select one");

   a_ack_holds_off: assert property (@(posedge core_clk) disable iff (rst)
      (state == ST_STROBE && cnt == 8'h0 && !ack_sync && cur.cond_true)
      |=> state == ST_STROBE) // R9
      else $error("access completed while acknowledge low");

   a_strobe_kind: assert property (@(posedge core_clk) disable iff (rst)
      (state == ST_STROBE && cur.cond_true) |-> (rd_n == cur.write) && (wr_n == !cur.write)) // R10
      else $error("wrong strobe for access");

   a_reset_levels: assert property (@(posedge core_clk)
      $past(rst) |-> mem_bank_select_n == SEL_IDLE && sdram_clk_en_out
      && !sdram_addr_bit_ten) // R11
      else $error("pin levels wrong after reset");
endmodule : ext_memory_select_pins

// File: test/ext_mem_partner.sv
// Behavioural model of the memories that sit across the external port.
// Assumes active-low strobes and selects; the bench sets the ack wait length.
`timescale 1ns/10ps
module ext_mem_partner (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic [3:0]  sel_n,
   input  wire logic        rd_n,
   input  wire logic        wr_n,
   input  wire logic [23:0] ext_addr,
   input  wire logic [3:0]  wait_cycles,
   output logic             ack_pin,
   output logic [31:0]      data_in
);
   logic [3:0]  wait_left;
   logic        strobe_seen;
   logic [31:0] last_word;
   logic        reading;

   // ==========================================================
   // Read data mirrors the address so the bench can predict it;
   // a released bus toggles so a stale value never looks valid
   assign reading = !rd_n && (sel_n != 4'hf);
   assign data_in = reading ? {8'ha5, ext_addr} : ~last_word;
   assign ack_pin = (wait_left == 4'h0);

   // Wait stretch starts at the falling strobe
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wait_left   <= 4'h0;
         strobe_seen <= 1'h0;
         last_word   <= 32'h0;
      end else begin
         strobe_seen <= !(rd_n && wr_n);
         last_word   <= data_in;
         if (!(rd_n && wr_n) && !strobe_seen) begin
            wait_left <= wait_cycles;
         end else if (wait_left != 4'h0) begin
            wait_left <= wait_left - 4'h1;
         end
      end
   end
endmodule : ext_mem_partner

// File: test/tb_top.sv
// Self-checking bench for the external memory pin logic.
// Assumes the partner model answers strobes; one core_clk domain.
`timescale 1ns/10ps
module tb_top;
   import ext_mem_pkg::*;
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
   $display("unexpected at %0t: got %0h exp %0h", $time, (g), (e)); end end

   typedef struct packed {
      logic [23:0] addr;
      logic        write;
      logic        cond;
      logic [3:0]  sel;
   } row_type;

   logic          core_clk = 1'h0, rst = 1'h1, req_valid = 1'h0, refresh_req = 1'h0;
   logic          sdram_sleep = 1'h0, boot_flash_pin = 1'h0;
   logic [3:0]    wait_cycles = 4'h0;
   mem_req_type   req = '0;
   wire           ack_pin, req_ready, resp_valid, refresh_busy, data_oe, rd_n, wr_n;
   wire           cke, bit_ten, sclk;
   wire [31:0]    data_in, data_out, resp_rdata;
   wire [23:0]    ext_addr;
   wire [3:0]     sel_n;
   wire sdram_cmd_type cmd;
   int            miscompares = 0, checks = 0, cycles;
   logic [3:0]    sel_seen;
   logic [23:0]   addr_seen;
   logic          rd_seen, wr_seen, par_ref, cke_act, ten_act, oe_seen, busy_seen, sclk_was;
   logic [31:0]   wdata_seen, rd_exp;
   // Plain cases: one access per bank, then a false conditional
   row_type rows [5] = '{'{24'h000400, 1'h0, 1'h1, 4'he}, '{24'h400400, 1'h1, 1'h1, 4'hd},
      '{24'h812345, 1'h0, 1'h1, 4'hb}, '{24'hc0abcd, 1'h1, 1'h1, 4'h7},
      '{24'h800010, 1'h0, 1'h0, 4'hb}};

   always #2 core_clk = ~core_clk;

   ext_memory_select_pins i_dut (.core_clk(core_clk), .rst(rst), .req_valid(req_valid),
      .req_ready(req_ready), .req(req), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
      .refresh_req(refresh_req), .refresh_busy(refresh_busy), .sdram_sleep(sdram_sleep),
      .boot_flash_pin(boot_flash_pin), .ack_pin(ack_pin), .data_in(data_in),
      .data_out(data_out), .data_oe(data_oe), .ext_addr(ext_addr), .rd_n(rd_n), .wr_n(wr_n),
      .mem_bank_select_n(sel_n), .sdram_clk_en_out(cke), .sdram_addr_bit_ten(bit_ten),
      .sdram_clock_out(sclk), .sdram_cmd(cmd));

   ext_mem_partner i_mem (.core_clk(core_clk), .rst(rst), .sel_n(sel_n), .rd_n(rd_n),
      .wr_n(wr_n), .ext_addr(ext_addr), .wait_cycles(wait_cycles), .ack_pin(ack_pin),
      .data_in(data_in));

   // ==========================================================
   // Verdict and the single exit point
   task automatic end_sim;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim

   // One access; records what the pins showed until the response pulse
   task automatic access(input logic [23:0] a, input logic w, input logic c);
      int n;
      @(posedge core_clk);
      req_valid <= 1'h1;
      req <= '{addr: a, write: w, cond_true: c, wdata: {8'h5a, a}};
      {sel_seen, rd_seen, wr_seen, par_ref, cke_act, ten_act, oe_seen, busy_seen} = {4'hf, 7'h0};
      wdata_seen = 32'h0;
      #1;
      for (n = 0; !req_ready; n++) begin
         if (n == 200) begin miscompares++; end_sim(); end
         @(posedge core_clk);
         #1;
      end
      @(posedge core_clk);
      req_valid <= 1'h0;
      #1;
      // Record before each wait, so the activate right after the take is seen
      for (cycles = 0; !resp_valid; cycles++) begin
         if (cycles == 300) begin miscompares++; end_sim(); end
         if (sel_n != 4'hf) begin sel_seen = sel_n; addr_seen = ext_addr; end
         rd_seen |= !rd_n;
         wr_seen |= !wr_n;
         busy_seen |= refresh_busy;
         if (data_oe) begin oe_seen = 1'h1; wdata_seen = data_out; end
         if (cmd === CMD_ACTIVATE) begin cke_act = cke; ten_act = bit_ten; end
         if (cmd === CMD_PRECHARGE && bit_ten && sel_n != 4'hf) par_ref = 1'h1;
         @(posedge core_clk);
         #1;
      end
   endtask : access

   // ==========================================================
   // Main sequence: reset, table, then the awkward cases
   initial begin
      repeat (10) @(posedge core_clk);
      #1 `CHK({sel_n, cke, bit_ten, rd_n, wr_n}, 8'hfb)
      repeat (10) @(posedge core_clk);
      rst <= 1'h0;
      repeat (2) @(posedge core_clk);
      #1 `CHK({sel_n, cke, bit_ten, rd_n, wr_n}, 8'hfb)
      foreach (rows[i]) begin
         access(rows[i].addr, rows[i].write, rows[i].cond);
         `CHK(sel_seen, rows[i].sel)
         `CHK(rd_seen, !rows[i].write && rows[i].cond)
         `CHK(wr_seen, rows[i].write && rows[i].cond)
         `CHK(addr_seen[10], rows[i].addr[10] && rows[i].sel != 4'he)
         `CHK({addr_seen[23:11], addr_seen[9:0]}, {rows[i].addr[23:11], rows[i].addr[9:0]})
         `CHK(sel_n, 4'hf)
         `CHK(cycles, STROBE_CYCLES + 2)
         `CHK(oe_seen, rows[i].write && rows[i].cond)
         if (oe_seen) `CHK(wdata_seen, {8'h5a, rows[i].addr})
         if (rows[i].sel == 4'he) `CHK(ten_act, rows[i].addr[10])
         // Partner echoes the pins, where SDRAM accesses park bit ten low
         rd_exp = {8'ha5, rows[i].addr[23:11], rows[i].addr[10] && rows[i].sel != 4'he,
                   rows[i].addr[9:0]};
         if (rd_seen) `CHK(resp_rdata, rd_exp)
      end
      // Flash boot moves a bank two access onto select one
      @(posedge core_clk);
      boot_flash_pin <= 1'h1;
      repeat (3) @(posedge core_clk);
      access(24'h800000, 1'h0, 1'h1);
      `CHK(sel_seen, SEL_FLASH)
      @(posedge core_clk);
      boot_flash_pin <= 1'h0;
      repeat (3) @(posedge core_clk);
      // Refresh requested while a non-SDRAM write is on the bus
      fork
         access(24'h800020, 1'h1, 1'h1);
         begin
            repeat (3) @(posedge core_clk);
            refresh_req <= 1'h1;
            @(posedge core_clk);
            refresh_req <= 1'h0;
         end
      join
      `CHK(par_ref, 1'h1)
      `CHK(busy_seen, 1'h1)
      `CHK(refresh_busy, 1'h0)
      // Sleep drops CKE; an SDRAM access must find it raised again
      @(posedge core_clk);
      sdram_sleep <= 1'h1;
      repeat (4) @(posedge core_clk);
      #1 `CHK(cke, 1'h0)
      @(posedge core_clk);
      sdram_sleep <= 1'h0;
      access(24'h000000, 1'h0, 1'h1);
      `CHK({cke_act, sel_seen}, 5'h1e)
      // Slow memory holds ack low, so the access must stretch
      @(posedge core_clk);
      wait_cycles <= 4'h8;
      access(24'hc00000, 1'h0, 1'h1);
      `CHK(cycles > 9, 1'h1)
      // SDRAM clock runs at half rate, so it flips on every rising core_clk edge
      @(posedge core_clk);
      #1 sclk_was = sclk;
      @(posedge core_clk);
      #1 `CHK(sclk, !sclk_was)
      end_sim();
   end
endmodule : tb_top
